// file: verilog/ebrh_arbiter.sv
// external bus cycle control with ready waits and hold arbitration
// Notes on behaviour
// R1: hold granted only after running cycle ends
// R2: ready sampled high inserts wait, resample
// R3: ready sampled low ends the cycle
// R4: far side drops ready after strobe rises
// R5: multiplexed bus adds trailer, optional tristate wait
// R6: trailer two clocks mux+tristate, zero demux
// R7: programmed wait states precede ready sampling
// R8: read/write delay moves strobe edge later
// R9: chip selects float while bus released
// R10: regain starts only when hold released
// R11: hold may drop without regain request
// R12: ready sampled sync or via synchroniser
// R13: hold low floats bus, ack low, reverse; on release the code raises ack and drives the bus on the same output clock
// R14: hold, ack, regain request on output clock
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "ebrh_params.svh"
module ebrh_arbiter
  import ebrh_pkg::*;
#(
  parameter int CS_COUNT = 5
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // local cycle request
  input wire logic cyc_req,
  input wire logic cyc_write,
  input wire logic [$clog2(CS_COUNT)-1:0] cyc_cs,
  output logic cyc_busy,
  output logic cyc_done,
  // external bus pins
  output logic system_clock_output,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic bus_oe,
  output logic [CS_COUNT-1:0] chip_select_line_n,
  output logic cs_oe,
  input wire logic ready_n,
  // arbitration pins
  input wire logic hold_n,
  output logic hold_grant_ack_n,
  output logic bus_regain_request_n
);
  localparam int CSW = $clog2(CS_COUNT);

  // elaboration check on the chip select count
  if (CS_COUNT < 2 || CS_COUNT > 8) begin : g_bad_cs
    $error("CS_COUNT must lie in 2..8");
  end

  ebrh_state_t state, next_state;
  ebrh_cfg_t cfg;
  logic clk_div;
  logic tick;
  logic [3:0] wait_cnt, next_wait_cnt;
  logic cur_write;
  logic [CSW-1:0] cur_cs;
  logic ready_sync;
  logic ready_smp;
  logic aw_got, w_got;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // output clock from a divider; tick marks its rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn)
      clk_div <= 1'b0;
    else
      clk_div <= ~clk_div;
  end
  assign tick = ~clk_div;
  assign system_clock_output = clk_div;

  // asynchronous ready path
  ebrh_ready_sync u_rdy_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(ready_n),
    .dout(ready_sync)
  );
  assign ready_smp = cfg.async_rdy ? ready_sync : ready_n; // R12

  function automatic logic strobe_on(ebrh_state_t s);
    return s == ST_MWAIT || s == ST_CMD;
  endfunction
  function automatic logic released(ebrh_state_t s);
    return s == ST_FLOAT || s == ST_HELD;
  endfunction

  // cycle and arbitration sequencer, stepped on output clock
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    if (tick) begin
      unique case (state)
        ST_IDLE: begin
          if (!hold_n)
            next_state = ST_FLOAT; // R1 R13 R14
          else if (cyc_req)
            next_state = ST_ADDR;
        end
        ST_ADDR: begin
          next_wait_cnt = cfg.wait_count;
          if (cfg.rw_delay)
            next_state = ST_DLY; // R8
          else if (cfg.wait_count != 4'h0)
            next_state = ST_MWAIT; // R7
          else
            next_state = ST_CMD;
        end
        ST_DLY: next_state = (wait_cnt != 4'h0) ? ST_MWAIT : ST_CMD; // R7
        ST_MWAIT: begin
          next_wait_cnt = wait_cnt - 4'h1;
          if (wait_cnt == 4'h1)
            next_state = ST_CMD; // R7
        end
        ST_CMD: begin
          if (!ready_smp)
            next_state = cfg.mux_en ? ST_MUXW
              : cfg.ttw_en ? ST_TTW : ST_IDLE; // R3 R5 R6
        end
        ST_MUXW: next_state = cfg.ttw_en ? ST_TTW : ST_IDLE; // R5 R6
        ST_TTW: next_state = ST_IDLE; // R6
        ST_FLOAT: next_state = ST_HELD; // R13
        ST_HELD: next_state = hold_n ? ST_REGAIN : ST_HELD; // R10 R11
        ST_REGAIN: next_state = ST_IDLE; // R13
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // state and latched cycle attributes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      wait_cnt <= 4'h0;
      cur_write <= 1'b0;
      cur_cs <= '0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      if (state == ST_IDLE && next_state == ST_ADDR) begin
        cur_write <= cyc_write;
        cur_cs <= cyc_cs;
      end
    end
  end

  // pin drivers registered from the next state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      bus_oe <= 1'b1;
      cs_oe <= 1'b1;
      hold_grant_ack_n <= 1'b1;
      cyc_busy <= 1'b0;
      cyc_done <= 1'b0;
    end else begin
      ale <= next_state == ST_ADDR;
      rd_n <= !(strobe_on(next_state) && !cur_write); // R8
      wr_n <= !(strobe_on(next_state) && cur_write); // R8
      bus_oe <= !released(next_state); // R13
      cs_oe <= !released(next_state); // R9
      hold_grant_ack_n <= next_state != ST_HELD; // R13 R14
      cyc_busy <= next_state != ST_IDLE && !released(next_state)
        && next_state != ST_REGAIN;
      cyc_done <= state == ST_CMD && next_state != ST_CMD; // R3
    end
  end

  // chip selects: active low on the selected line
  generate
    for (genvar i = 0; i < CS_COUNT; i++) begin : g_cs
      always_ff @(posedge aclk) begin
        if (!aresetn)
          chip_select_line_n[i] <= 1'b1;
        else
          chip_select_line_n[i] <= !(cur_cs == CSW'(i)
            && (next_state == ST_DLY || strobe_on(next_state)));
      end
    end
  endgenerate

  // regain request while held and work is pending
  always_ff @(posedge aclk) begin
    if (!aresetn)
      bus_regain_request_n <= 1'b1;
    else if (tick)
      bus_regain_request_n <= !(state == ST_HELD && hold_n == 1'b0
        && (cyc_req || cfg.regain_sw)); // R10 R14
  end

  // axi write channel: address and data in either order
  wire wr_go = aw_got && w_got && !s_axi_bvalid;
  wire wr_ctrl = aw_addr == `EBRH_CTRL_OFS;
  wire wr_stat = aw_addr == `EBRH_STAT_OFS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EBRH_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ctrl || wr_stat) ? `EBRH_RESP_OKAY
          : `EBRH_RESP_SLVERR;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // control register, bits 8:0 writable
  always_ff @(posedge aclk) begin
    if (!aresetn)
      cfg <= ebrh_cfg_t'(`EBRH_CTRL_RST);
    else if (wr_go && wr_ctrl) begin
      if (w_strb[0])
        cfg[7:0] <= w_data[7:0];
      if (w_strb[1])
        cfg[8] <= w_data[`EBRH_CTRL_REQ_BIT];
    end
  end

  // axi read channel, answer one cycle after address
  wire [31:0] stat_word = {25'h0, ready_smp, !hold_n,
    released(state), state};
  wire rd_ctrl = s_axi_araddr == `EBRH_CTRL_OFS;
  wire rd_stat = s_axi_araddr == `EBRH_STAT_OFS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `EBRH_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ctrl ? {23'h0, cfg} : rd_stat ? stat_word
        : 32'h0000_0000;
      s_axi_rresp <= (rd_ctrl || rd_stat) ? `EBRH_RESP_OKAY
        : `EBRH_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks on the sequencer
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_hold_after_cycle;
    (state == ST_FLOAT && $past(state) != ST_FLOAT)
      |-> $past(state) == ST_IDLE;
  endproperty
  a_hold_after_cycle: assert property (p_hold_after_cycle) // R1
    else $error("bus released during a running cycle");
  property p_ready_wait;
    (state == ST_CMD && tick && ready_smp) |=> state == ST_CMD;
  endproperty
  a_ready_wait: assert property (p_ready_wait) // R2
    else $error("ready high did not hold the cycle");
  property p_ready_end;
    (state == ST_CMD && tick && !ready_smp)
      |=> state != ST_CMD && rd_n && wr_n && cyc_done;
  endproperty
  a_ready_end: assert property (p_ready_end) // R3
    else $error("ready low did not end the cycle");
  property p_mux_trailer;
    (state == ST_CMD && tick && !ready_smp && cfg.mux_en && cfg.ttw_en)
      |=> state == ST_MUXW ##2 state == ST_TTW ##2 state == ST_IDLE;
  endproperty
  a_mux_trailer: assert property (p_mux_trailer) // R5
    else $error("multiplexed trailer is not two output clocks");
  property p_demux_trailer;
    (state == ST_CMD && tick && !ready_smp && !cfg.mux_en
      && !cfg.ttw_en) |=> state == ST_IDLE;
  endproperty
  a_demux_trailer: assert property (p_demux_trailer) // R6
    else $error("demultiplexed trailer not zero");
  property p_wait_states;
    (state == ST_MWAIT && tick && wait_cnt > 4'h1)
      |=> state == ST_MWAIT && !(rd_n && wr_n);
  endproperty
  a_wait_states: assert property (p_wait_states) // R7
    else $error("wait states cut short");
  property p_rw_delay;
    (state == ST_ADDR && tick && cfg.rw_delay)
      |=> (state == ST_DLY && rd_n && wr_n) [*2];
  endproperty
  a_rw_delay: assert property (p_rw_delay) // R8
    else $error("strobe not delayed");
  property p_cs_float;
    state == ST_HELD |-> !cs_oe && !bus_oe && !hold_grant_ack_n;
  endproperty
  a_cs_float: assert property (p_cs_float) // R9
    else $error("chip selects driven while held");
  property p_regain_on_release;
    (state == ST_HELD && tick && !hold_n) |=> state == ST_HELD;
  endproperty
  a_regain_on_release: assert property (p_regain_on_release) // R10
    else $error("regain started while hold still low");
  property p_regain_any;
    (state == ST_HELD && tick && hold_n && bus_regain_request_n)
      |=> state == ST_REGAIN ##1 hold_grant_ack_n ##1 bus_oe;
  endproperty
  a_regain_any: assert property (p_regain_any) // R11
    else $error("no regain without a regain request");
  property p_ack_sync;
    $changed(hold_grant_ack_n) |-> $past(tick);
  endproperty
  a_ack_sync: assert property (p_ack_sync) // R14
    else $error("hold ack changed off the output clock");

  c_waited: cover property (state == ST_CMD && tick && ready_smp);
  c_held: cover property (state == ST_HELD ##[1:40] state == ST_IDLE);
  c_mux: cover property (state == ST_TTW);
endmodule

// file: verilog/ebrh_params.svh
// constants for the external bus ready and hold arbiter
`ifndef EBRH_PARAMS_SVH
`define EBRH_PARAMS_SVH
// register byte offsets
`define EBRH_CTRL_OFS 4'h0
`define EBRH_STAT_OFS 4'h4
// control field positions
`define EBRH_CTRL_WAIT_LSB 0
`define EBRH_CTRL_MUX_BIT 4
`define EBRH_CTRL_TTW_BIT 5
`define EBRH_CTRL_RWD_BIT 6
`define EBRH_CTRL_ASY_BIT 7
`define EBRH_CTRL_REQ_BIT 8
`define EBRH_CTRL_RST 32'h0000_0000
// axi responses
`define EBRH_RESP_OKAY 2'h0
`define EBRH_RESP_SLVERR 2'h2
// output clock: aclk divided by two
`define EBRH_CLK_PERIOD_NS 4
`define EBRH_SYSTEM_CLOCK_OUTPUT_DIV 2
`endif

// file: verilog/ebrh_pkg.sv
// types for the external bus ready and hold arbiter
package ebrh_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_DLY = 4'b0010,
    ST_MWAIT = 4'b0011,
    ST_CMD = 4'b0100,
    ST_MUXW = 4'b0101,
    ST_TTW = 4'b0110,
    ST_FLOAT = 4'b0111,
    ST_HELD = 4'b1000,
    ST_REGAIN = 4'b1001
  } ebrh_state_t;
  typedef struct packed {
    logic regain_sw;
    logic async_rdy;
    logic rw_delay;
    logic ttw_en;
    logic mux_en;
    logic [3:0] wait_count;
  } ebrh_cfg_t;
endpackage

// file: verilog/ebrh_ready_sync.sv
// two-stage synchroniser for the asynchronous ready input
`timescale 1ns/10ps
module ebrh_ready_sync
  import ebrh_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic meta;

  // first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// file: verif/ebrh_mem_model.sv
// external memory model answering strobes with ready
`timescale 1ns/10ps
module ebrh_mem_model
  import ebrh_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // strobes seen on the bus
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic bus_oe,
  // one less than the clocks of strobe low before ready
  input wire logic [7:0] dly,
  // ready back to the device
  output logic ready_n
);
  logic [7:0] cnt;
  wire strobe_on = bus_oe & ~(rd_n & wr_n);
  // count strobe clocks, pull-up level once the strobe ends
  always_ff @(posedge aclk) begin
    if (!aresetn || !strobe_on) begin
      cnt <= 8'h00;
      ready_n <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
      if (cnt == dly) begin
        ready_n <= 1'b0;
      end
    end
  end
endmodule

// file: verif/ext_bus_ready_hold_arbiter_tb.sv
// bench for the external bus ready and hold arbiter
`timescale 1ns/10ps
module ext_bus_ready_hold_arbiter_tb;
  import ebrh_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, cyc_req, cyc_write;
  logic cyc_busy, cyc_done, system_clock_output, ale, rd_n, wr_n;
  logic bus_oe, cs_oe, ready_n, hold_n, hold_grant_ack_n;
  logic bus_regain_request_n;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] cyc_cs;
  logic [4:0] chip_select_line_n;
  logic [7:0] dly;
  int error_cnt, num_checks, cyc_cnt, ts0, td0, tn0, ts, td, tn;

  ebrh_arbiter #(.CS_COUNT(5)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cyc_req,
    .cyc_write, .cyc_cs, .cyc_busy, .cyc_done, .system_clock_output, .ale,
    .rd_n, .wr_n, .bus_oe, .chip_select_line_n, .cs_oe, .ready_n, .hold_n,
    .hold_grant_ack_n, .bus_regain_request_n);
  ebrh_mem_model mem (.aclk, .aresetn, .rd_n, .wr_n, .bus_oe, .dly,
    .ready_n);

  // clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // watchdog
  always @(posedge aclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  // axi4-lite write, both channels offered together
  task automatic axi_wr(logic [3:0] a, logic [31:0] d, logic [1:0] r);
    // let an edge pass so bready is not driven twice in one step
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", r, s_axi_bresp);
  endtask

  // axi4-lite read with masked compare
  task automatic axi_rd(logic [3:0] a, logic [31:0] m, logic [31:0] e,
      logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata & m);
    chk("rresp", r, s_axi_rresp);
  endtask

  // two back-to-back cycles; times from first ale
  task automatic run(logic [31:0] cfg, logic [7:0] d, logic w,
      logic [2:0] cs, output int s, output int dn, output int nx);
    int n = 0;
    int t0 = -1;
    s = -1;
    dn = -1;
    nx = -1;
    axi_wr(4'h0, cfg, 2'h0);
    dly <= d;
    cyc_write <= w;
    cyc_cs <= cs;
    cyc_req <= 1'b1;
    while (nx < 0) begin
      @(posedge aclk);
      n++;
      if (ale && t0 < 0) t0 = n;
      if (!(rd_n && wr_n) && s < 0) begin
        s = n - t0;
        chk("cs", {27'h0, ~(5'h01 << cs)}, chip_select_line_n);
        chk("strobe", w ? 3'b010 : 3'b001, {ale, rd_n, wr_n});
      end
      if (dn >= 0 && n == t0 + dn + 1) begin
        chk("done_pulse", 3'b011, {cyc_done, rd_n, wr_n});
      end
      if (dn >= 0 && ale) nx = n - t0;
      if (cyc_done && dn < 0) dn = n - t0;
    end
    cyc_req <= 1'b0;
    @(posedge aclk iff cyc_done);
    @(posedge aclk iff !cyc_busy);
    repeat (8) @(posedge aclk);
  endtask

  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, cyc_req, cyc_write} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, cyc_cs} = 15'h0078;
    {s_axi_wdata, dly, hold_n} = 41'h0_0000_0001;
    {error_cnt, num_checks, cyc_cnt} = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // registers: reset, mask, read-only, unmapped
    axi_rd(4'h0, 32'hffff_ffff, 32'h0000_0000, 2'h0);
    axi_wr(4'h0, 32'hffff_ffff, 2'h0);
    axi_rd(4'h0, 32'hffff_ffff, 32'h0000_01ff, 2'h0);
    axi_wr(4'h4, 32'hffff_ffff, 2'h0);
    axi_wr(4'h8, 32'hffff_ffff, 2'h2);
    axi_rd(4'h8, 32'hffff_ffff, 32'h0000_0000, 2'h2);
    // cycle timing relative to a plain demultiplexed read, wait states relative to a one-wait-state write
    run(32'h0000_0000, 8'h05, 1'b0, 3'h0, ts0, td0, tn0);
    run(32'h0000_0040, 8'h05, 1'b1, 3'h2, ts, td, tn);
    chk("rw_delay", 2, ts - ts0);
    run(32'h0000_0000, 8'h09, 1'b0, 3'h1, ts, td, tn);
    chk("ready_wait", 4, td - td0);
    run(32'h0000_0001, 8'h01, 1'b1, 3'h4, ts, td0, tn);
    run(32'h0000_0003, 8'h01, 1'b1, 3'h4, ts, td, tn);
    chk("wait_states", 4, td - td0);
    run(32'h0000_0000, 8'h05, 1'b0, 3'h3, ts0, td0, tn0);
    run(32'h0000_0010, 8'h05, 1'b0, 3'h3, ts, td, tn);
    chk("mux_trailer", 2, (tn - td) - (tn0 - td0));
    run(32'h0000_0030, 8'h05, 1'b0, 3'h3, ts, td, tn);
    chk("mux_ttw", 4, (tn - td) - (tn0 - td0));
    run(32'h0000_0020, 8'h05, 1'b0, 3'h3, ts, td, tn);
    chk("ttw_only", 2, (tn - td) - (tn0 - td0));
    run(32'h0000_0080, 8'h05, 1'b0, 3'h3, ts, td, tn);
    chk("async_ready", 2, td - td0);
    // hold arrives mid-cycle
    axi_wr(4'h0, 32'h0000_0000, 2'h0);
    dly <= 8'h09;
    cyc_req <= 1'b1;
    @(posedge aclk iff !(rd_n && wr_n));
    hold_n <= 1'b0;
    cyc_req <= 1'b0;
    @(posedge aclk iff cyc_done);
    chk("ack_in_cycle", 2'b11, {hold_grant_ack_n, bus_oe});
    @(posedge aclk iff !hold_grant_ack_n);
    chk("released", 2'b00, {bus_oe, cs_oe});
    chk("system_clock_output_ack", 1'b1, system_clock_output);
    axi_rd(4'h4, 32'h0000_003f, 32'h0000_0038, 2'h0);
    cyc_req <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("held_req", 3'b000, {bus_regain_request_n, hold_grant_ack_n,
      cyc_busy});
    hold_n <= 1'b1;
    @(posedge aclk iff hold_grant_ack_n);
    @(posedge aclk iff cyc_done);
    chk("regained", 2'b11, {bus_oe, cs_oe});
    cyc_req <= 1'b0;
    // hold dropped without a regain request
    hold_n <= 1'b0;
    @(posedge aclk iff !hold_grant_ack_n);
    repeat (4) @(posedge aclk);
    chk("no_regain", 1'b1, bus_regain_request_n);
    hold_n <= 1'b1;
    @(posedge aclk iff hold_grant_ack_n);
    repeat (4) @(posedge aclk);
    chk("back", 2'b11, {bus_oe, cs_oe});
    // software regain request while held
    axi_wr(4'h0, 32'h0000_0100, 2'h0);
    hold_n <= 1'b0;
    @(posedge aclk iff !hold_grant_ack_n);
    repeat (4) @(posedge aclk);
    chk("sw_regain", 2'b00, {bus_regain_request_n,
      hold_grant_ack_n});
    hold_n <= 1'b1;
    @(posedge aclk iff hold_grant_ack_n);
    test_done();
  end
endmodule
